// File: src/drs_top.sv
// Purpose: Hardware reset sequencer of the display controller
// Assumes: hw_reset_n comes from the host, asynchronous to sys_clk
// Notes:   NVM answers a read in the same cycle its strobe stands; reload is a fixed word list
//
// How it works
// - Ignore under 5us; reset beyond 9us
// - Reload NVM settings after every release
// - Blank display, then default state
// - Glitches inside reset are filtered too
// - Cancel 5ms asleep, 120ms awake
`timescale 1ns/10ps
module drs_top #(
    parameter int unsigned REJECT    = drs_pkg::REJECT_CYC,
    parameter int unsigned FULL      = drs_pkg::FULL_CYC,
    parameter int unsigned CAN_SLEEP = drs_pkg::CANCEL_SLEEP_CYC,
    parameter int unsigned CAN_AWAKE = drs_pkg::CANCEL_AWAKE_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Host reset pin
    input  wire logic        hw_reset_n,
    // Core status
    input  wire logic        sleep_mode,
    // NVM read data
    input  wire logic [7:0]  nvm_data,
    // Outputs
    output drs_pkg::drs_nvm_t nvm,
    output logic             blank,
    output logic             core_reset,
    output logic             ready
);
    // The counters must hold the longest cancel period; a zero reject time has no meaning
    if (REJECT == 0 || FULL < REJECT || CAN_SLEEP == 0
        || CAN_AWAKE >= (1 << drs_pkg::CNT_W) || CAN_SLEEP > CAN_AWAKE) begin : g_bad_timing
        $error("drs_top: bad timing parameters");
    end

    typedef struct packed {
        drs_pkg::drs_state_t     st;
        logic [drs_pkg::CNT_W-1:0] cnt;
        logic [drs_pkg::CNT_W-1:0] lowcnt;
        logic                    awake;
        logic [3:0]              idx;
        drs_pkg::drs_nvm_t       nvm;
        logic                    blank;
        logic                    core_reset;
        logic                    ready;
    } drs_regs_t;

    drs_regs_t r;
    drs_regs_t next_r;
    logic      pin_lvl;

    drs_sync u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pin     (hw_reset_n),
        .level   (pin_lvl)
    );

    always_comb begin
        next_r        = r;
        next_r.nvm.rd = 1'b0;
        next_r.nvm.wr = 1'b0;
        // Low time counter, saturating
        if (!pin_lvl) begin
            if (r.lowcnt != {drs_pkg::CNT_W{1'b1}})
                next_r.lowcnt = r.lowcnt + 1'b1;
        end else begin
            next_r.lowcnt = '0;
        end
        unique case (r.st)
            drs_pkg::DRS_RUN: begin
                // Mode at the first low picks the cancel length
                if (!pin_lvl) begin
                    next_r.st    = drs_pkg::DRS_FILTER;
                    next_r.awake = !sleep_mode;
                end
            end
            drs_pkg::DRS_FILTER: begin
                // Short spikes while ready return to normal operation untouched
                if (pin_lvl && r.lowcnt < REJECT[drs_pkg::CNT_W-1:0]) begin
                    if (r.ready) begin
                        next_r.st = drs_pkg::DRS_RUN;
                    end else begin
                        // A spike cut the reload or cancel; redo both, never stall not ready
                        next_r.st  = drs_pkg::DRS_RELOAD;
                        next_r.cnt = '0;
                        next_r.idx = '0;
                    end
                end else if (r.lowcnt >= REJECT[drs_pkg::CNT_W-1:0]) begin
                    // Between limits we start reset; beyond FULL it is certain
                    next_r.st         = drs_pkg::DRS_HELD;
                    // Stale count from a past cancel would end the hold at once
                    next_r.cnt        = '0;
                    next_r.ready      = 1'b0;
                    next_r.blank      = 1'b1;
                    next_r.core_reset = 1'b1;
                end
            end
            drs_pkg::DRS_HELD: begin
                // A high spike shorter than REJECT is not a release
                if (pin_lvl) begin
                    if (r.cnt >= REJECT[drs_pkg::CNT_W-1:0] - 1) begin
                        next_r.st  = drs_pkg::DRS_RELOAD;
                        next_r.cnt = '0;
                        next_r.idx = '0;
                        next_r.core_reset = 1'b0;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end else begin
                    next_r.cnt = '0;
                end
            end
            drs_pkg::DRS_RELOAD: begin
                next_r.cnt = r.cnt + 1'b1;
                // Issue reads, write back each word one cycle later
                if (r.idx != 4'(drs_pkg::RELOAD_WORDS))
                    next_r.nvm.rd = 1'b1;
                next_r.nvm.addr = r.idx[2:0];
                if (r.nvm.rd) begin
                    next_r.nvm.wr   = 1'b1;
                    next_r.nvm.data = nvm_data;
                end
                if (r.idx != 4'(drs_pkg::RELOAD_WORDS))
                    next_r.idx = r.idx + 1'b1;
                else if (!r.nvm.rd)
                    next_r.st = drs_pkg::DRS_CANCEL;
                if (!pin_lvl) begin
                    next_r.st = drs_pkg::DRS_FILTER;
                    next_r.lowcnt = '0;
                end
            end
            drs_pkg::DRS_CANCEL: begin
                // Reload cycles count toward the cancel limit, so it is not exceeded unless the limit is shorter than the reload
                next_r.cnt = r.cnt + 1'b1;
                // Awake entry needs the full blanking time
                if (r.cnt >= (r.awake ? CAN_AWAKE[drs_pkg::CNT_W-1:0]
                                      : CAN_SLEEP[drs_pkg::CNT_W-1:0]) - 1) begin
                    next_r.st    = drs_pkg::DRS_RUN;
                    next_r.ready = 1'b1;
                    next_r.awake = 1'b0;
                    // Default state after reset is sleep, panel stays blank
                end
                if (!pin_lvl)
                    next_r.st = drs_pkg::DRS_FILTER;
            end
            default: next_r.st = drs_pkg::DRS_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r            <= '0;
            r.st         <= drs_pkg::DRS_RUN;
            r.ready      <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign nvm        = r.nvm;
    assign blank      = r.blank;
    assign core_reset = r.core_reset;
    assign ready      = r.ready;

    short_spike_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        r.st == drs_pkg::DRS_FILTER && pin_lvl && r.lowcnt < REJECT && ready
        |=> r.st == drs_pkg::DRS_RUN && !core_reset)
        else $error("short pulse started a reset");
    long_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !pin_lvl && r.lowcnt == FULL
        |=> core_reset)
        else $error("long pulse not taken");
    reset_blank_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        core_reset |-> blank && !ready)
        else $error("reset without blanking");
    reload_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(r.st == drs_pkg::DRS_RELOAD) |=> nvm.rd)
        else $error("reload did not start");
    glitch_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        r.st == drs_pkg::DRS_HELD && !pin_lvl ##1 pin_lvl |=> core_reset)
        else $error("glitch released reset");
    ready_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        r.st inside {drs_pkg::DRS_RELOAD, drs_pkg::DRS_CANCEL} |-> !ready)
        else $error("ready during reload or cancel");
    cancel_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(ready) |-> $past(r.st) == drs_pkg::DRS_CANCEL)
        else $error("ready rose outside cancel");
    blank_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(core_reset) |-> blank && $past(r.st) == drs_pkg::DRS_FILTER)
        else $error("blank not raised with reset");
    spike_resume_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        r.st == drs_pkg::DRS_FILTER && pin_lvl && r.lowcnt < REJECT && !ready
        |=> r.st == drs_pkg::DRS_RELOAD && !core_reset && !ready)
        else $error("spike in cancel not resumed");
    reload_pair_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        nvm.rd && r.st == drs_pkg::DRS_RELOAD
        |=> nvm.wr && nvm.data == $past(nvm_data))
        else $error("reload read not written back");
    held_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        r.st == drs_pkg::DRS_HELD && pin_lvl && r.cnt < REJECT - 1
        |=> core_reset && r.st == drs_pkg::DRS_HELD)
        else $error("short high released reset");
    state_onehot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $onehot(r.st))
        else $error("state code not one-hot");
endmodule // drs_top

// File: shared/drs_pkg.sv
// Purpose: Shared constants and types for the display reset sequencer
// Assumes: 100 MHz system clock
// Notes:   Times are kept in their own units; cycle counts derive from them
package drs_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned CLK_KHZ        = 100000;
    // Spike filter limits in microseconds
    localparam int unsigned REJECT_US      = 5;
    localparam int unsigned FULL_US        = 9;
    // Cancel periods in milliseconds
    localparam int unsigned CANCEL_SLEEP_MS = 5;
    localparam int unsigned CANCEL_AWAKE_MS = 120;
    // Cycle counts are exact products of time and clock rate, no rounding
    localparam int unsigned REJECT_CYC     = REJECT_US * CLK_MHZ;
    localparam int unsigned FULL_CYC       = FULL_US * CLK_MHZ;
    localparam int unsigned CANCEL_SLEEP_CYC = CANCEL_SLEEP_MS * CLK_KHZ;
    localparam int unsigned CANCEL_AWAKE_CYC = CANCEL_AWAKE_MS * CLK_KHZ;
    localparam int unsigned RELOAD_WORDS   = 8;
    localparam int unsigned CNT_W          = 24;

    typedef enum logic [4:0] {
        DRS_RUN    = 5'h01,
        DRS_FILTER = 5'h02,
        DRS_HELD   = 5'h04,
        DRS_RELOAD = 5'h08,
        DRS_CANCEL = 5'h10
    } drs_state_t;

    // Reload port towards non-volatile storage and configuration registers
    typedef struct packed {
        logic       rd;
        logic [2:0] addr;
        logic       wr;
        logic [7:0] data;
    } drs_nvm_t;
endpackage

// File: src/drs_sync.sv
// Purpose: Two-stage synchroniser for the reset pin
// Assumes: Single clock domain after this stage
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module drs_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Pin and synchronised level
    input  wire logic pin,
    output logic      level
);
    logic meta;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta  <= 1'b1;
            level <= 1'b1;
        end else begin
            meta  <= pin;
            level <= meta;
        end
    end
endmodule // drs_sync

// File: testbench/drs_host.sv
// Purpose: Host-side model: reset pin driver and NVM store
// Assumes: Pin changes 1 ns after a clock edge
// Notes:   Idle NVM data toggles so a stale byte never matches
`timescale 1ns/10ps
module drs_host (
    // Clock
    input  wire logic        sys_clk,
    // NVM port
    input  drs_pkg::drs_nvm_t nvm,
    output logic [7:0]       nvm_data,
    // Reset pin
    output logic             hw_reset_n
);
    logic [7:0] idle_q = 8'h00;
    initial begin
        hw_reset_n = 1'b1;
    end
    // Idle byte flips every cycle, never inside the word range
    always @(posedge sys_clk) begin
        idle_q <= ~idle_q;
    end
    // Word i holds a8 plus i, shown while its read strobe stands
    always_comb begin
        nvm_data = nvm.rd ? {5'h15, nvm.addr} : idle_q;
    end
    // Low for lo cycles; if hi is set, a high gap then lo2 more low cycles
    task automatic pulse(input int lo, input int hi, input int lo2);
        @(posedge sys_clk) #1 hw_reset_n = 1'b0;
        repeat (lo) @(posedge sys_clk);
        if (hi > 0) begin
            #1 hw_reset_n = 1'b1;
            repeat (hi) @(posedge sys_clk);
            #1 hw_reset_n = 1'b0;
            repeat (lo2) @(posedge sys_clk);
        end
        #1 hw_reset_n = 1'b1;
    endtask
endmodule // drs_host

// File: testbench/tb.sv
// Purpose: Self-checking bench of the reset sequencer
// Assumes: Small filter and cancel counts set by parameter
// Notes:   Cancel span is counted from release and includes the reload
`timescale 1ns/10ps
module tb;
    localparam int REJ = 5;
    localparam int CS  = 50;
    localparam int CA  = 120;
    logic             sys_clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             sleep_mode = 1'b1;
    logic [7:0]       nvm_data;
    logic             hw_reset_n;
    drs_pkg::drs_nvm_t nvm;
    logic             blank, core_reset, ready, prev_cr, bexp;
    int               n_fail = 0, n_compared = 0, rises, post, seed_v;
    logic [7:0]       wq[$];
    always #5 sys_clk = ~sys_clk;
    drs_top #(.REJECT(REJ), .FULL(9), .CAN_SLEEP(CS), .CAN_AWAKE(CA)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n),
        .sleep_mode(sleep_mode), .nvm_data(nvm_data), .nvm(nvm),
        .blank(blank), .core_reset(core_reset), .ready(ready));
    drs_host host (.sys_clk(sys_clk), .nvm(nvm), .nvm_data(nvm_data),
        .hw_reset_n(hw_reset_n));
    // Monitor: reload writes, reset rises, cycles not ready after release
    always @(posedge sys_clk) begin
        if (nvm.wr === 1'b1) wq.push_back(nvm.data);
        if (core_reset === 1'b1 && prev_cr !== 1'b1) rises++;
        if (ready === 1'b0 && core_reset === 1'b0) post++;
        prev_cr = core_reset;
    end
    task automatic check(input string what, input int exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run(input string name, input int lo, input int hi, input int lo2,
                       input logic slp, input logic rst);
        int t;
        int c;
        @(posedge sys_clk) #1;
        wq.delete();
        rises = 0;
        post = 0;
        sleep_mode = slp;
        bexp = bexp | rst;
        c = slp ? CS : CA;
        host.pulse(lo, hi, lo2);
        t = 0;
        while (ready !== 1'b1 && t < 400) begin
            @(posedge sys_clk);
            t++;
        end
        repeat (5) @(posedge sys_clk);
        check("reset rises", rst, rises);
        check("ready", 1, ready);
        check("blank", bexp, blank);
        check("reload words", rst ? 8 : 0, wq.size());
        for (int i = 0; i < wq.size(); i++) check("reload data", 'ha8 + i, wq[i]);
        // Reload lies inside the cancel period, so ready stays low exactly c cycles after core_reset falls
        if (rst) check("cancel span", c, post);
        // No command follows here, but keep the host quiet the full wait
        repeat (CA) @(posedge sys_clk);
        $display("Test %s done", name);
    endtask
    initial begin
        bexp = 1'b0;
        prev_cr = 1'b0;
        seed_v = $urandom(33);
        repeat (12) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        check("ready after reset", 1, ready);
        check("blank after reset", 0, blank);
        run("short", 1 + $urandom % 3, 0, 0, 1'b0, 1'b0);
        run("edge", REJ - 1, 0, 0, 1'b1, 1'b0);
        run("sleep", 12 + $urandom % 20, 0, 0, 1'b1, 1'b1);
        run("awake", 12 + $urandom % 20, 0, 0, 1'b0, 1'b1);
        run("glitch", 10, 2, 10, 1'b1, 1'b1);
        end_of_test();
    end
    // Tests need about a thousand cycles; this limit is far beyond that
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
endmodule // tb
